// ### include/cfa_core_regs.svh
// Register offsets, field positions, reset values and instruction fields of cfa_core.
// Assumes inclusion by its bare name from the package; the design file uses the macros without including it.
`ifndef CFA_CORE_REGS_SVH
`define CFA_CORE_REGS_SVH

// Register port
`define CFA_ADDR_W          4
`define CFA_REG_PCL         4'h0
`define CFA_REG_ACC         4'h1
`define CFA_REG_STATUS      4'h2
`define CFA_REG_CTRL        4'h3

// Status register fields
`define CFA_ST_C            0
`define CFA_ST_AC           1
`define CFA_ST_Z            2
`define CFA_ST_OV           3
`define CFA_STATUS_RST      8'h00

// Control register fields
`define CFA_CTRL_SLOW       0
`define CFA_CTRL_IEN        1
`define CFA_CTRL_RST        8'h00

// Program counter, stack and accumulator reset
`define CFA_PC_W            11
`define CFA_RESET_VEC       11'h000
`define CFA_STACK_LEVELS    8
`define CFA_ACC_RST         8'h00

// Instruction word fields
`define CFA_OP_MSB          15
`define CFA_OP_LSB          12
`define CFA_BIT_DSTM        11
`define CFA_BIT_CARRY       10
`define CFA_BIT_ALT         9
`define CFA_BIT_SKIPZ       8
`define CFA_BIT_INTERRUPT_RETURN        0

`endif

// ### include/cfa_pkg.sv
// Types shared by the fetch, stack and ALU sequencer.
// Assumes cfa_core_regs.svh on the include path.
package cfa_pkg;
    `include "cfa_core_regs.svh"

    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} cfa_phase_t;

    typedef enum logic [3:0] {
        OP_NOP, OP_JMP, OP_CALL, OP_RET, OP_ADD, OP_SUB, OP_AND, OP_OR,
        OP_XOR, OP_CPL, OP_ROT, OP_INCDEC, OP_DAA, OP_SKIP, OP_LDA, OP_WPCL
    } cfa_op_t;
endpackage

// ### hdl/cfa_core.sv
// Four-phase fetch/execute sequencer with 11-bit program counter, 8-level return stack, 8-bit ALU.
// Assumes program memory answers prog_addr_o by phase T4 and data memory is on the same clock.
//
// The register offsets and the strobed register port were decided locally.
module cfa_core #(
    parameter int                 SLOW_DIV = 4,
    parameter logic [10:0]        IRQ_VEC  = 11'h004
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    output logic [10:0]           prog_addr_o,
    input  wire logic [15:0]      prog_data_i,
    output logic [7:0]            mem_addr_o,
    output logic [7:0]            mem_wdata_o,
    output logic                  mem_we_o,
    input  wire logic [7:0]       mem_rdata_i,
    input  wire logic             irq_req_i,
    output logic                  irq_ack_o,
    output cfa_pkg::cfa_phase_t   phase_o,
    input  wire logic [3:0]       reg_addr_i,
    input  wire logic [7:0]       reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output logic [7:0]            reg_rdata_o
);
    import cfa_pkg::*;

    localparam int DIV_W = (SLOW_DIV > 1) ? $clog2(SLOW_DIV) : 1;
    cfa_phase_t        phase;
    logic [DIV_W-1:0]  div_cnt;
    logic              ph_en;
    logic              commit;
    logic [10:0]       pc;
    logic [15:0]       ir;
    logic              ir_valid;
    logic [7:0]        acc;
    logic [7:0]        status;
    logic              slow_sel;
    logic              ien;
    logic              irq_pend;
    logic              pcl_pend;
    logic [7:0]        pcl_val;
    logic [10:0]       stk [`CFA_STACK_LEVELS];
    logic [2:0]        top;
    logic [3:0]        depth;
    logic              full;
    cfa_op_t           op;
    logic [7:0]        m;
    logic [7:0]        res;
    logic [7:0]        next_status;
    logic              wr_a;
    logic              wr_m;
    logic              do_branch;
    logic [10:0]       br_target;
    logic              do_push;
    logic              do_pop;
    logic              do_skip;
    logic              set_ien;
    logic              irq_take;
    logic              pcl_apply;
    logic              flush;
    logic [10:0]       next_pc;
    // Sum in [7:0], carry [8], half carry [9], overflow [10]
    function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
        logic [8:0] s;
        logic [4:0] h;
        s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        return {(a[7] == b[7]) && (s[7] != a[7]), h[4], s};
    endfunction
    // Slow oscillator modelled as enable from a divider
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt <= '0;
        end else if (!slow_sel || div_cnt == DIV_W'(SLOW_DIV - 1)) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + DIV_W'(1);
        end
    end

    assign ph_en  = !slow_sel || (div_cnt == DIV_W'(SLOW_DIV - 1));
    assign commit = ph_en && (phase == PH_T4);
    assign phase_o = phase;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase <= PH_T1;
        end else if (ph_en) begin
            phase <= cfa_phase_t'(phase + 2'd1);
        end
    end

    assign full = (depth == 4'(`CFA_STACK_LEVELS));
    assign m    = mem_rdata_i;
    assign op   = cfa_op_t'(ir[`CFA_OP_MSB:`CFA_OP_LSB]);

    // Decode and execute of the instruction held in ir
    always_comb begin
        logic [10:0] sum;
        logic [7:0]  adj;
        logic        hi;
        sum         = '0;
        adj         = '0;
        hi          = 1'b0;
        res         = 8'h00;
        next_status = status;
        wr_a        = 1'b0;
        wr_m        = 1'b0;
        do_branch   = 1'b0;
        br_target   = pc;
        do_push     = 1'b0;
        do_pop      = 1'b0;
        do_skip     = 1'b0;
        set_ien     = 1'b0;
        if (ir_valid) begin
            unique case (op)
                OP_NOP: ;
                OP_JMP, OP_CALL: begin
                    do_branch = 1'b1;
                    br_target = ir[10:0];
                    do_push   = (op == OP_CALL);
                end
                OP_RET: begin
                    do_branch = 1'b1;
                    do_pop    = 1'b1;
                    br_target = stk[top - 3'd1];
                    set_ien   = ir[`CFA_BIT_INTERRUPT_RETURN];
                end
                OP_ADD, OP_SUB: begin
                    sum = add8(acc, (op == OP_SUB) ? ~m : m,
                               ir[`CFA_BIT_CARRY] ? status[`CFA_ST_C] : (op == OP_SUB));
                    res = sum[7:0];
                    next_status[`CFA_ST_C]  = sum[8];
                    next_status[`CFA_ST_AC] = sum[9];
                    next_status[`CFA_ST_OV] = sum[10];
                    next_status[`CFA_ST_Z]  = (sum[7:0] == 8'h00);
                    wr_m = ir[`CFA_BIT_DSTM];
                    wr_a = !ir[`CFA_BIT_DSTM];
                end
                OP_AND, OP_OR, OP_XOR, OP_CPL: begin
                    unique case (op)
                        OP_AND:  res = acc & m;
                        OP_OR:   res = acc | m;
                        OP_XOR:  res = acc ^ m;
                        default: res = ~m;
                    endcase
                    next_status[`CFA_ST_Z] = (res == 8'h00);
                    wr_m = ir[`CFA_BIT_DSTM];
                    wr_a = !ir[`CFA_BIT_DSTM];
                end
                OP_ROT: begin
                    if (ir[`CFA_BIT_ALT]) begin
                        res = {m[6:0], ir[`CFA_BIT_CARRY] ? status[`CFA_ST_C] : m[7]};
                    end else begin
                        res = {ir[`CFA_BIT_CARRY] ? status[`CFA_ST_C] : m[0], m[7:1]};
                    end
                    if (ir[`CFA_BIT_CARRY]) begin
                        next_status[`CFA_ST_C] = ir[`CFA_BIT_ALT] ? m[7] : m[0];
                    end
                    wr_m = ir[`CFA_BIT_DSTM];
                    wr_a = !ir[`CFA_BIT_DSTM];
                end
                OP_INCDEC: begin
                    res = ir[`CFA_BIT_ALT] ? m - 8'h01 : m + 8'h01;
                    next_status[`CFA_ST_Z] = (res == 8'h00);
                    do_skip = ir[`CFA_BIT_SKIPZ] && (res == 8'h00);
                    wr_m = ir[`CFA_BIT_DSTM];
                    wr_a = !ir[`CFA_BIT_DSTM];
                end
                OP_DAA: begin
                    adj = acc;
                    if (adj[3:0] > 4'h9 || status[`CFA_ST_AC]) begin
                        adj = adj + 8'h06;
                    end
                    hi = (acc > 8'h99) || status[`CFA_ST_C];
                    res = hi ? adj + 8'h60 : adj;
                    next_status[`CFA_ST_C] = hi;
                    wr_m = ir[`CFA_BIT_DSTM];
                    wr_a = !ir[`CFA_BIT_DSTM];
                end
                OP_SKIP: begin
                    do_skip = ir[`CFA_BIT_ALT] ? (m != 8'h00) : (m == 8'h00);
                end
                OP_LDA: begin
                    res  = ir[7:0];
                    wr_a = 1'b1;
                end
                OP_WPCL: begin
                    do_branch = 1'b1;
                    br_target = {pc[10:8], acc};
                end
            endcase
        end
    end

    // Deferred while the stack is full or another transfer is in progress
    assign irq_take  = commit && irq_pend && ien && !full && !do_branch && !pcl_pend;
    assign pcl_apply = commit && pcl_pend && !do_branch;
    assign flush     = do_branch || do_skip || irq_take || pcl_apply;

    always_comb begin
        if (irq_take) begin
            next_pc = IRQ_VEC;
        end else if (do_branch) begin
            next_pc = br_target;
        end else if (pcl_apply) begin
            next_pc = {pc[10:8], pcl_val};
        end else begin
            next_pc = pc + 11'h001;
        end
    end

    // Counter steps on the edge that begins T1; the word at the new address is latched into ir at the end of T4
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pc <= `CFA_RESET_VEC;
        end else if (commit) begin
            pc <= next_pc;
        end
    end

    assign prog_addr_o = pc;
    // Prefetch overlaps execution; a flushed fetch becomes a dummy cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ir       <= 16'h0000;
            ir_valid <= 1'b0;
        end else if (commit) begin
            ir       <= prog_data_i;
            ir_valid <= (!flush && (op != OP_CALL || !ir_valid));
        end
    end

    // Return stack, circular so an overflowing call drops the oldest entry
    always_ff @(posedge clk_i) begin
        if (commit && (do_push || irq_take)) begin
            stk[top] <= pc;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            top   <= 3'd0;
            depth <= 4'd0;
        end else if (commit && (do_push || irq_take)) begin
            top   <= top + 3'd1;
            depth <= full ? depth : depth + 4'd1;
        end else if (commit && do_pop && depth != 4'd0) begin
            top   <= top - 3'd1;
            depth <= depth - 4'd1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc    <= `CFA_ACC_RST;
            status <= `CFA_STATUS_RST;
        end else if (commit) begin
            status <= next_status;
            if (wr_a) begin
                acc <= res;
            end
        end
    end

    // Memory write is issued in T1 while the old operand address still stands
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mem_we_o    <= 1'b0;
            mem_wdata_o <= 8'h00;
            mem_addr_o  <= 8'h00;
        end else begin
            mem_we_o <= commit && wr_m;
            if (commit && wr_m) begin
                mem_wdata_o <= res;
            end
            if (ph_en && phase == PH_T1) begin
                mem_addr_o <= ir[7:0];
            end
        end
    end

    // Request flag: a new request beats the clear from acknowledge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_pend  <= 1'b0;
            irq_ack_o <= 1'b0;
        end else begin
            irq_pend  <= irq_req_i || (irq_pend && !irq_take);
            irq_ack_o <= irq_take;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            slow_sel <= 1'b0;
            ien      <= 1'b0;
        end else begin
            if (reg_wr_i && reg_addr_i == `CFA_REG_CTRL) begin
                slow_sel <= reg_wdata_i[`CFA_CTRL_SLOW];
                ien      <= reg_wdata_i[`CFA_CTRL_IEN];
            end
            if (irq_take) begin
                ien <= 1'b0;
            end else if (commit && set_ien) begin
                ien <= 1'b1;
            end
        end
    end

    // Low byte write waits for the next instruction boundary without a branch; a later write replaces it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pcl_pend <= 1'b0;
            pcl_val  <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == `CFA_REG_PCL) begin
            pcl_pend <= 1'b1;
            pcl_val  <= reg_wdata_i;
        end else if (pcl_apply) begin
            pcl_pend <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                `CFA_REG_PCL:    reg_rdata_o <= pc[7:0];
                `CFA_REG_ACC:    reg_rdata_o <= acc;
                `CFA_REG_STATUS: reg_rdata_o <= status;
                `CFA_REG_CTRL:   reg_rdata_o <= {6'h00, ien, slow_sel};
                default:         reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
    a_phase_steps: assert property (@(posedge clk_i) disable iff (rst_i)
        ph_en |=> phase == cfa_phase_t'($past(phase) + 2'd1))
        else $error("phase did not advance");
    a_pc_increment: assert property (@(posedge clk_i) disable iff (rst_i)
        commit && !flush |=> pc == $past(pc) + 11'h001)
        else $error("counter did not advance by one");
    a_jump_dummy: assert property (@(posedge clk_i) disable iff (rst_i)
        commit && ir_valid && op == OP_JMP |=> !ir_valid && pc == $past(ir[10:0]))
        else $error("jump missed target or dummy cycle");
    a_skip_dummy: assert property (@(posedge clk_i) disable iff (rst_i)
        commit && do_skip |=> !ir_valid)
        else $error("skip kept prefetched instruction");
    a_call_push: assert property (@(posedge clk_i) disable iff (rst_i)
        commit && ir_valid && op == OP_CALL && !full |=> depth == $past(depth) + 4'd1)
        else $error("call did not push");
    a_call_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
        commit && ir_valid && op == OP_CALL && full |=> full && top == $past(top) + 3'd1)
        else $error("overflow call misbehaved");
    a_ret_pop: assert property (@(posedge clk_i) disable iff (rst_i)
        commit && do_pop && depth != 4'd0
        |=> pc == stk[top] && depth == $past(depth) - 4'd1)
        else $error("return did not restore counter");
    a_empty_ret: assert property (@(posedge clk_i) disable iff (rst_i)
        commit && do_pop && depth == 4'd0 |=> depth == 4'd0)
        else $error("empty return moved pointer");
    a_irq_withheld: assert property (@(posedge clk_i) disable iff (rst_i)
        full && irq_pend |=> !irq_ack_o)
        else $error("acknowledge with full stack");
    a_pcl_page: assert property (@(posedge clk_i) disable iff (rst_i)
        pcl_apply |=> pc == {$past(pc[10:8]), $past(pcl_val)} && !ir_valid)
        else $error("low byte write left page or kept prefetch");
    a_zero_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        commit && ir_valid && (op == OP_AND || op == OP_ADD) && wr_a
        |=> status[`CFA_ST_Z] == (acc == 8'h00))
        else $error("zero flag disagrees with result");

endmodule // cfa_core

// ### sim/cfa_prog_mem.sv
// Program memory model facing the fetch port of cfa_core.
// Assumes the fetch address holds for a whole instruction cycle.
module cfa_prog_mem #(
    parameter int LAT = 3
) (
    input  wire logic        clk_i,
    input  wire logic [10:0] addr_i,
    output logic      [15:0] data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] words [2048];
    logic [10:0] last = 11'h000;
    int          cnt  = 0;

    // Access time counted from each address change
    always_ff @(posedge clk_i) begin
        if (addr_i != last) begin
            last <= addr_i;
            cnt  <= 1;
        end else if (cnt < LAT) begin
            cnt <= cnt + 1;
        end
    end

    // Word not yet ready shows the inverse of the word at last, the new address after one clock
    always_comb data_o = (addr_i == last && cnt >= LAT) ? words[addr_i] : ~words[last];
endmodule // cfa_prog_mem

// ### sim/cfa_core_tb_top.sv
// Self-checking bench for cfa_core: ALU table, branches, stack, interrupt, low byte writes.
// Assumes cfa_pkg and cfa_prog_mem compiled first; data memory lives here.
module cfa_core_tb_top;
    import cfa_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end

    typedef struct {logic [15:0] op, w2; logic [7:0] a, m, ea, em, sm, es;} cfa_row_t;
    localparam logic [10:0] IRQV = 11'h004;
    localparam logic [15:0] J2   = 16'h1002;
    localparam logic [15:0] L7   = 16'hE077;

    logic        clk_i;
    logic        rst_i       = 1'b1;
    logic        reg_wr_i    = 1'b0;
    logic        reg_rd_i    = 1'b0;
    logic        irq_req_i   = 1'b0;
    logic [3:0]  reg_addr_i  = 4'h0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic [10:0] prog_addr_o;
    logic [15:0] prog_data_i;
    logic [7:0]  mem_addr_o, mem_wdata_o, mem_rdata_i, reg_rdata_o;
    logic        mem_we_o, irq_ack_o;
    cfa_phase_t  phase_o;
    logic [7:0]  dm [256] = '{default: 8'h00};
    int          num_errors = 0;
    int          check_count = 0;
    int          ack_cnt = 0;

    // Columns: op, third word, acc in, mem in, acc out, mem out, status mask, status out
    cfa_row_t rows [17] = '{
        '{16'h4010, J2, 8'h7F, 8'h01, 8'h80, 8'h01, 8'h0F, 8'h0A},
        '{16'h5010, J2, 8'h05, 8'h05, 8'h00, 8'h05, 8'h05, 8'h05},
        '{16'h6010, J2, 8'hF0, 8'h3C, 8'h30, 8'h3C, 8'h04, 8'h00},
        '{16'h7010, J2, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04},
        '{16'h8010, J2, 8'hFF, 8'h0F, 8'hF0, 8'h0F, 8'h04, 8'h00},
        '{16'h9010, J2, 8'h00, 8'h5A, 8'hA5, 8'h5A, 8'h00, 8'h00},
        '{16'hA210, J2, 8'h81, 8'h81, 8'h03, 8'h81, 8'h00, 8'h00},
        '{16'hA010, J2, 8'h81, 8'h81, 8'hC0, 8'h81, 8'h00, 8'h00},
        '{16'hA610, J2, 8'h81, 8'h81, 8'h02, 8'h81, 8'h01, 8'h01},
        '{16'hA410, J2, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h01},
        '{16'hB010, J2, 8'hFF, 8'hFF, 8'h00, 8'hFF, 8'h04, 8'h04},
        '{16'hB210, J2, 8'h01, 8'h01, 8'h00, 8'h01, 8'h04, 8'h04},
        '{16'hC010, J2, 8'h0A, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00},
        '{16'h4810, J2, 8'h01, 8'h02, 8'h01, 8'h03, 8'h00, 8'h00},
        '{16'hD010, L7, 8'h11, 8'h00, 8'h11, 8'h00, 8'h00, 8'h00},
        '{16'hD010, L7, 8'h11, 8'h01, 8'h77, 8'h01, 8'h00, 8'h00},
        '{16'hD210, L7, 8'h11, 8'h01, 8'h11, 8'h01, 8'h00, 8'h00}
    };

    cfa_core #(.SLOW_DIV(2), .IRQ_VEC(IRQV)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .prog_addr_o(prog_addr_o), .prog_data_i(prog_data_i),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_we_o(mem_we_o),
        .mem_rdata_i(mem_rdata_i), .irq_req_i(irq_req_i), .irq_ack_o(irq_ack_o),
        .phase_o(phase_o), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o)
    );
    cfa_prog_mem #(.LAT(3)) pm_u (.clk_i(clk_i), .addr_i(prog_addr_o), .data_o(prog_data_i));

    assign mem_rdata_i = dm[mem_addr_o];
    always @(posedge clk_i) begin
        if (mem_we_o === 1'b1) dm[mem_addr_o] <= mem_wdata_o;
        if (irq_ack_o === 1'b1) ack_cnt++;
    end

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic complete_run;
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic do_reset;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i  <= ad;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] ad, output logic [7:0] d);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask

    // Fetch address at the next entry into the first phase, and clocks taken
    task automatic next_t1(output logic [10:0] a, output int n);
        n = 0;
        do begin @(posedge clk_i); #1; n++; end while (phase_o === PH_T1 && n < 99);
        do begin @(posedge clk_i); #1; n++; end while (phase_o !== PH_T1 && n < 99);
        a = prog_addr_o;
    endtask

    task automatic seq(input logic [10:0] e [$]);
        logic [10:0] a;
        int          n;
        foreach (e[i]) begin
            next_t1(a, n);
            `CHK(a, e[i])
        end
    endtask

    task automatic wait_pc(input logic [10:0] t, input int lim);
        int n;
        n = 0;
        while (prog_addr_o !== t && n < lim) begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask

    task automatic run_row(input cfa_row_t r);
        logic [7:0] v;
        pm_u.words    = '{default: 16'h0000};
        pm_u.words[0] = {8'hE0, r.a};
        pm_u.words[1] = r.op;
        pm_u.words[2] = r.w2;
        pm_u.words[3] = 16'h1003;
        dm[8'h10]     = r.m;
        do_reset;
        repeat (24) @(posedge clk_i);
        rd(`CFA_REG_ACC, v);
        `CHK(v, r.ea)
        rd(`CFA_REG_STATUS, v);
        `CHK(v & r.sm, r.es)
        `CHK(dm[8'h10], r.em)
    endtask

    initial begin
        #400000;
        num_errors++;
        complete_run;
    end

    initial begin
        logic [10:0] a;
        logic [7:0]  v;
        int          n;
        foreach (rows[i]) run_row(rows[i]);
        wr(`CFA_REG_ACC, 8'h55);
        rd(`CFA_REG_ACC, v);
        `CHK(v, 8'h11)
        rd(4'hF, v);
        `CHK(v, 8'h00)
        // Call, return, jump, then the slow clock
        pm_u.words        = '{default: 16'h0000};
        pm_u.words[0]     = 16'h2100;
        pm_u.words[11'h100] = 16'h3000;
        pm_u.words[2]     = 16'h1123;
        pm_u.words[11'h123] = 16'h1123;
        do_reset;
        `CHK(prog_addr_o, 11'h000)
        seq('{11'h001, 11'h100, 11'h101, 11'h001, 11'h002, 11'h003, 11'h123, 11'h124});
        next_t1(a, n);
        `CHK(n, 4)
        wr(`CFA_REG_CTRL, 8'h01);
        next_t1(a, n);
        next_t1(a, n);
        `CHK(n, 8)
        // Nine nested calls, full stack, held interrupt, low byte write
        pm_u.words = '{default: 16'h0000};
        for (int k = 0; k < 9; k++) pm_u.words[k * 16] = 16'h2000 | 16'((k + 1) * 16);
        for (int k = 2; k < 9; k++) pm_u.words[k * 16 + 1] = 16'h3000;
        pm_u.words[11'h082] = 16'h3000;
        pm_u.words[11'h090] = 16'h1590;
        pm_u.words[11'h590] = 16'h1590;
        pm_u.words[11'h591] = 16'h3000;
        pm_u.words[11'h011] = 16'h13FF;
        pm_u.words[11'h001] = 16'h12FF;
        pm_u.words[11'h3FF] = 16'h13FF;
        pm_u.words[IRQV]    = 16'h3001;
        do_reset;
        wr(`CFA_REG_CTRL, 8'h02);
        wait_pc(11'h590, 400);
        `CHK(prog_addr_o, 11'h590)
        ack_cnt = 0;
        irq_req_i <= 1'b1;
        repeat (40) @(posedge clk_i);
        irq_req_i <= 1'b0;
        `CHK(ack_cnt, 0)
        rd(`CFA_REG_PCL, v);
        `CHK(v & 8'hFE, 8'h90)
        wr(`CFA_REG_PCL, 8'h91);
        wait_pc(11'h592, 60);
        `CHK(prog_addr_o, 11'h592)
        next_t1(a, n);
        `CHK(a, 11'h081)
        repeat (40) @(posedge clk_i);
        `CHK(ack_cnt, 1)
        wait_pc(11'h3FF, 800);
        `CHK(prog_addr_o, 11'h3FF)
        complete_run;
    end
endmodule // cfa_core_tb_top
